// File: core/cmp_ctrl.sv
`timescale 1ns/1ps
module cmp_ctrl #(
  parameter int NCMP = 2
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // AXI4-Lite write address
  input wire logic [13:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [13:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Analog front end
  input wire logic [NCMP-1:0] COMPARATOR_RAW,
  output logic [NCMP-1:0] COMPARATOR_ON,
  output logic [NCMP-1:0] REFERENCE_SOURCE_SELECT,
  output logic [2*NCMP-1:0] INVERTING_CHANNEL_SELECT,
  // Pins and interrupt
  output logic [NCMP-1:0] COMPARATOR_RESULT_PIN,
  output logic [NCMP-1:0] COMPARATOR_RESULT_PIN_OE,
  output logic IRQ
);
  import cmp_pkg::*;

  logic [7:0] ctrl_q [NCMP], ctrl_d [NCMP];
  logic [NCMP-1:0] flag_q, flag_d;
  logic [NCMP-1:0] mask_q, mask_d;
  logic [NCMP-1:0] result;
  logic [NCMP-1:0] ev;
  logic [NCMP-1:0] eset;

  // Write channel state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [13:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  // Read channel state
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic arready_q, arready_d;
  // Output registers
  logic [NCMP-1:0] on_q, on_d;
  logic [NCMP-1:0] ref_q, ref_d;
  logic [2*NCMP-1:0] ch_q, ch_d;
  logic [NCMP-1:0] pin_q, pin_d;
  logic [NCMP-1:0] pin_oe_q, pin_oe_d;
  logic irq_q, irq_d;

  logic do_write;
  logic [13:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_ok;
  logic [NCMP-1:0] clr;

  genvar g;
  generate
    for (g = 0; g < NCMP; g++) begin : gen_cmp
      cmp_chan_if cif ();
      assign cif.ctrl = ctrl_q[g];
      assign cif.raw_result = COMPARATOR_RAW[g];
      cmp_channel u_chan (
        .clk(CLK_SYS),
        .nrst(NRST),
        .ch(cif)
      );
      assign result[g] = cif.result;
      assign ev[g] = cif.event_pulse;
      assign eset[g] = cif.edge_set;
    end
  endgenerate

  // Address and data may arrive in either order; both are held until used
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    if (S_AXI_AWVALID && !aw_held_q) begin
      aw_held_d = 1'b1;
      awaddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_held_q) begin
      w_held_d = 1'b1;
      wdata_d = S_AXI_WDATA;
      wstrb_d = S_AXI_WSTRB;
    end
    do_write = aw_held_q && w_held_q && !bvalid_q;
    wa = awaddr_q;
    wd = wdata_q;
    ws = wstrb_q;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
    end
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    wr_ok = (wa == CTRL_FIRST_ADDR) || (wa == CTRL_SECOND_ADDR) ||
            (wa == IRQ_STATUS_ADDR) || (wa == IRQ_MASK_ADDR) || (wa == STATE_ADDR);
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Readies come from flops that track the next hold state
    awready_d = !aw_held_d;
    wready_d = !w_held_d;
  end

  // Control, mask and sticky flag registers
  always_comb begin
    clr = '0;
    mask_d = mask_q;
    for (int i = 0; i < NCMP; i++) begin
      ctrl_d[i] = ctrl_q[i];
    end
    // Byte lane zero carries every register
    if (do_write && ws[0]) begin
      if (wa == CTRL_FIRST_ADDR) begin
        ctrl_d[0] = wd[7:0];
      end else if (wa == CTRL_SECOND_ADDR && NCMP > 1) begin
        ctrl_d[NCMP-1] = wd[7:0];
      end else if (wa == IRQ_STATUS_ADDR) begin
        clr = wd[NCMP-1:0];
      end else if (wa == IRQ_MASK_ADDR) begin
        mask_d = wd[NCMP-1:0];
      end
    end
    // A new event beats a clear in the same cycle
    flag_d = (flag_q & ~clr) | ev | eset;
  end

  // Read channel, one access at a time
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (S_AXI_ARADDR == CTRL_FIRST_ADDR) begin
        rdata_d[7:0] = ctrl_q[0];
      end else if (S_AXI_ARADDR == CTRL_SECOND_ADDR) begin
        rdata_d[7:0] = ctrl_q[NCMP-1];
      end else if (S_AXI_ARADDR == IRQ_STATUS_ADDR) begin
        rdata_d[NCMP-1:0] = flag_q;
      end else if (S_AXI_ARADDR == IRQ_MASK_ADDR) begin
        rdata_d[NCMP-1:0] = mask_q;
      end else if (S_AXI_ARADDR == STATE_ADDR) begin
        rdata_d[NCMP-1:0] = result;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  // Pin and analog control outputs
  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      on_d[i] = ctrl_q[i][ON_BIT];
      ref_d[i] = ctrl_q[i][REF_BIT];
      ch_d[2*i+1] = ctrl_q[i][CH_HI];
      ch_d[2*i] = ctrl_q[i][CH_LO];
      // Pin copy and its enable move in the same cycle
      pin_oe_d[i] = ctrl_q[i][PIN_OE_BIT];
      pin_d[i] = ctrl_q[i][PIN_OE_BIT] & result[i];
    end
    // Level interrupt, one cycle behind the flags
    irq_d = |(flag_q & mask_q);
  end

  // Control, mask and flag state
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NCMP; i++) begin
        ctrl_q[i] <= CTRL_RESET;
      end
      flag_q <= '0;
      mask_q <= MASK_RESET;
    end else begin
      for (int i = 0; i < NCMP; i++) begin
        ctrl_q[i] <= ctrl_d[i];
      end
      flag_q <= flag_d;
      mask_q <= mask_d;
    end
  end

  // Write channel state
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 14'h0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  // Read channel state
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      arready_q <= arready_d;
    end
  end

  // Output registers
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      on_q <= '0;
      ref_q <= '0;
      ch_q <= '0;
      pin_q <= '0;
      pin_oe_q <= '0;
      irq_q <= 1'b0;
    end else begin
      on_q <= on_d;
      ref_q <= ref_d;
      ch_q <= ch_d;
      pin_q <= pin_d;
      pin_oe_q <= pin_oe_d;
      irq_q <= irq_d;
    end
  end

  // Every port comes straight from a flop, so no logic glitch reaches the bus
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign COMPARATOR_ON = on_q;
  assign REFERENCE_SOURCE_SELECT = ref_q;
  assign INVERTING_CHANNEL_SELECT = ch_q;
  assign COMPARATOR_RESULT_PIN = pin_q;
  assign COMPARATOR_RESULT_PIN_OE = pin_oe_q;
  assign IRQ = irq_q;
endmodule

// File: core/cmp_pkg.sv
package cmp_pkg;
  localparam int ADDR_W = 12;
  // Register byte addresses: register index times four
  localparam logic [11:0] CTRL_FIRST_IDX = 12'hfd1;
  localparam logic [11:0] CTRL_SECOND_IDX = 12'hfd2;
  localparam logic [13:0] CTRL_FIRST_ADDR = {CTRL_FIRST_IDX, 2'b00};
  localparam logic [13:0] CTRL_SECOND_ADDR = {CTRL_SECOND_IDX, 2'b00};
  localparam logic [13:0] IRQ_STATUS_ADDR = 14'h0000;
  localparam logic [13:0] IRQ_MASK_ADDR = 14'h0004;
  localparam logic [13:0] STATE_ADDR = 14'h0008;
  // Field positions of a control register
  localparam int ON_BIT = 7;
  localparam int PIN_OE_BIT = 6;
  localparam int INVERT_BIT = 5;
  localparam int EDGE_HI = 4;
  localparam int EDGE_LO = 3;
  localparam int REF_BIT = 2;
  localparam int CH_HI = 1;
  localparam int CH_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h1f;
  localparam logic [1:0] MASK_RESET = 2'h0;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY  = 2'b11
  } edge_sel_t;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: core/cmp_chan_if.sv
`timescale 1ns/1ps
interface cmp_chan_if;
  logic [7:0] ctrl;
  logic raw_result;
  logic result;
  logic event_pulse;
  logic edge_set;
  modport owner (output ctrl, output raw_result, input result, input event_pulse, input edge_set);
  modport chan (input ctrl, input raw_result, output result, output event_pulse, output edge_set);
endinterface

// File: core/cmp_channel.sv
`timescale 1ns/1ps
module cmp_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control and result
  cmp_chan_if.chan ch
);
  import cmp_pkg::*;
  logic res_q, res_d;
  logic prev_q, prev_d;
  logic [1:0] edge_q, edge_d;
  logic pulse;
  logic rise;
  logic fall;
  edge_sel_t sel;

  always_comb begin
    sel = edge_sel_t'(ch.ctrl[EDGE_HI:EDGE_LO]);
    // Disabled comparator holds a low result
    res_d = ch.ctrl[ON_BIT] & (ch.raw_result ^ ch.ctrl[INVERT_BIT]);
    prev_d = res_q;
    edge_d = ch.ctrl[EDGE_HI:EDGE_LO];
    rise = res_q & ~prev_q;
    fall = ~res_q & prev_q;
    case (sel)
      EDGE_RISE: pulse = rise;
      EDGE_FALL: pulse = fall;
      EDGE_ANY: pulse = rise | fall;
      default: pulse = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_q <= 1'b0;
      prev_q <= 1'b0;
      edge_q <= CTRL_RESET[EDGE_HI:EDGE_LO];
    end else begin
      res_q <= res_d;
      prev_q <= prev_d;
      edge_q <= edge_d;
    end
  end

  assign ch.result = res_q;
  assign ch.event_pulse = pulse;
  // Entering any-change mode sets the flag once
  assign ch.edge_set = (sel == EDGE_ANY) && (edge_q != EDGE_ANY);
endmodule

// File: testbench/cmp_ctrl_asserts.sv
`timescale 1ns/1ps
module cmp_ctrl_asserts #(parameter int NCMP = 2) (
  input logic CLK_SYS,
  input logic NRST,
  input logic S_AXI_AWVALID,
  input logic S_AXI_AWREADY,
  input logic S_AXI_WVALID,
  input logic S_AXI_WREADY,
  input logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  input logic [NCMP-1:0] COMPARATOR_ON,
  input logic [NCMP-1:0] COMPARATOR_RESULT_PIN,
  input logic [NCMP-1:0] COMPARATOR_RESULT_PIN_OE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // Pin flop may lag the enable by one stage
  sequence s_off3;
    !COMPARATOR_ON[0] [*3];
  endsequence
  property p_w_lat;
    s_wr_taken |-> ##[1:3] S_AXI_BVALID;
  endproperty
  property p_b_once;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  property p_r_lat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  property p_r_once;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY;
  endproperty
  property p_ar_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  property p_rdata_hi;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0;
  endproperty
  property p_pin_oe;
    (COMPARATOR_RESULT_PIN & ~COMPARATOR_RESULT_PIN_OE) == '0;
  endproperty
  property p_off_low;
    s_off3 |-> !COMPARATOR_RESULT_PIN[0];
  endproperty
  a_w_lat: assert property (p_w_lat)
    else $error("write answer late");
  a_b_once: assert property (p_b_once)
    else $error("write answer repeated");
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  a_r_once: assert property (p_r_once)
    else $error("read answer repeated");
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while busy");
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("read upper bits set");
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin driven without enable");
  a_off_low: assert property (p_off_low)
    else $error("pin high while off");
endmodule
bind cmp_ctrl cmp_ctrl_asserts #(.NCMP(NCMP)) u_chk (.*);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cmp_pkg::*;
  logic CLK_SYS = 1'b0, NRST = 1'b0;
  logic [13:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf, INVERTING_CHANNEL_SELECT;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  logic [1:0] COMPARATOR_RAW = '0, S_AXI_BRESP, S_AXI_RRESP, COMPARATOR_ON;
  logic [1:0] REFERENCE_SOURCE_SELECT, COMPARATOR_RESULT_PIN, COMPARATOR_RESULT_PIN_OE;
  int failures = 0, tests_run = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  cmp_ctrl #(.NCMP(2)) DUT (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [1:0] e);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk(32'(S_AXI_BRESP), 32'(e));
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, e);
    chk(32'(S_AXI_RRESP), 32'(r));
  endtask
  task automatic stop_test;
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    stop_test();
  end
  initial begin
    tick(5);
    NRST <= 1'b1;
    tick(2);
    chk(32'(REFERENCE_SOURCE_SELECT), 32'h3);
    chk(32'(COMPARATOR_ON), 32'h0);
    chk(32'(INVERTING_CHANNEL_SELECT), 32'hf);
    chk({30'h0, S_AXI_AWREADY, S_AXI_ARREADY}, 32'h3);
    rd(CTRL_FIRST_ADDR, 32'h1f);
    wr(14'h0100, 32'h1, RESP_SLVERR);
    rd(14'h0100, 32'h0, RESP_SLVERR);
    wr(IRQ_MASK_ADDR, 32'h3, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_FIRST_ADDR, 32'h80 | 32'(m << 3), RESP_OKAY);
      tick(4);
      rd(IRQ_STATUS_ADDR, 32'(m == 3));
      wr(IRQ_STATUS_ADDR, 32'h3, RESP_OKAY);
      for (int v = 1; v >= 0; v--) begin
        COMPARATOR_RAW[0] <= v[0];
        tick(5);
        chk(32'(IRQ), 32'(v ? m[0] : m[1]));
        wr(IRQ_STATUS_ADDR, 32'h3, RESP_OKAY);
      end
    end
    wr(CTRL_FIRST_ADDR, 32'he0, RESP_OKAY);
    tick(4);
    chk(32'(COMPARATOR_RESULT_PIN), 32'h1);
    chk(32'(INVERTING_CHANNEL_SELECT), 32'hc);
    rd(STATE_ADDR, 32'h1);
    COMPARATOR_RAW <= 2'h3;
    wr(CTRL_FIRST_ADDR, 32'h80, RESP_OKAY);
    tick(4);
    chk(32'(COMPARATOR_RESULT_PIN_OE), 32'h0);
    chk(32'(COMPARATOR_RESULT_PIN), 32'h0);
    rd(STATE_ADDR, 32'h1);
    wr(CTRL_SECOND_ADDR, 32'h84, RESP_OKAY);
    wr(CTRL_FIRST_ADDR, 32'h0, RESP_OKAY);
    tick(4);
    chk({28'h0, COMPARATOR_ON, REFERENCE_SOURCE_SELECT}, 32'ha);
    rd(STATE_ADDR, 32'h2);
    // Lane zero strobe low leaves the register alone
    S_AXI_WSTRB <= 4'he;
    wr(CTRL_FIRST_ADDR, 32'hff, RESP_OKAY);
    S_AXI_WSTRB <= 4'hf;
    rd(CTRL_FIRST_ADDR, 32'h0);
    // Masked flag must still latch in status
    wr(IRQ_MASK_ADDR, 32'h0, RESP_OKAY);
    wr(CTRL_SECOND_ADDR, 32'h98, RESP_OKAY);
    tick(4);
    rd(IRQ_STATUS_ADDR, 32'h2);
    chk(32'(IRQ), 32'h0);
    wr(IRQ_MASK_ADDR, 32'h2, RESP_OKAY);
    tick(3);
    chk(32'(IRQ), 32'h1);
    wr(IRQ_STATUS_ADDR, 32'h2, RESP_OKAY);
    tick(3);
    chk(32'(IRQ), 32'h0);
    stop_test();
  end
endmodule
